//--- rtl/odcpc_pkg.sv
package odcpc_pkg;

	// ****************************************************************
	// Command word layout
	// ****************************************************************
	localparam int          WORD_W       = 24;
	localparam int          CMD_MSB      = 23;
	localparam int          CMD_LSB      = 20;
	localparam int          ADDR_MSB     = 19;
	localparam int          ADDR_LSB     = 16;
	localparam int          DATA_MSB     = 15;
	localparam int          PD_HI_BIT    = 9;
	localparam int          PD_LO_BIT    = 8;
	localparam int          CLR_SEL_HI   = 1;
	localparam int          CLR_SEL_LO   = 0;
	localparam int          REF_EN_BIT   = 0;
	localparam int          NUM_CH       = 8;
	localparam int          BIT_CNT_W    = 5;
	localparam logic [4:0]  LAST_BIT     = 5'h17;
	localparam logic [3:0]  ADDR_ALL     = 4'hf;

	// ****************************************************************
	// Command codes
	// ****************************************************************
	localparam logic [3:0]  CMD_WR_INPUT = 4'h0;
	localparam logic [3:0]  CMD_UPD_DAC  = 4'h1;
	localparam logic [3:0]  CMD_WR_UPD_ALL = 4'h2;
	localparam logic [3:0]  CMD_WR_UPD_N = 4'h3;
	localparam logic [3:0]  CMD_POWER    = 4'h4;
	localparam logic [3:0]  CMD_CLR_CODE = 4'h5;
	localparam logic [3:0]  CMD_SW_RESET = 4'h7;
	localparam logic [3:0]  CMD_REF      = 4'h8;

	// ****************************************************************
	// Power-down modes and clear codes
	// ****************************************************************
	typedef enum logic [1:0] {
		PD_NORMAL   = 2'b00,
		PD_1K_GND   = 2'b01,
		PD_100K_GND = 2'b10,
		PD_TRISTATE = 2'b11
	} odcpc_pd_mode_t;

	localparam logic [1:0]  CLR_SEL_ZERO = 2'h0;
	localparam logic [1:0]  CLR_SEL_MID  = 2'h1;
	localparam logic [1:0]  CLR_SEL_FULL = 2'h2;
	localparam logic [1:0]  CLR_SEL_NOP  = 2'h3;
	localparam logic [15:0] CODE_ZERO    = 16'h0000;
	localparam logic [15:0] CODE_MID     = 16'h8000;
	localparam logic [15:0] CODE_FULL    = 16'hffff;
	localparam logic        REF_RESET    = 1'h0;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int          CLK_PERIOD_NS = 20;
	localparam int          WAKE_TIME_NS  = 4000;
	localparam int          WAKE_CYCLES   = (WAKE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int          WAKE_CNT_W    = 8;
	localparam int          POR_CYCLES    = 16;
	localparam int          POR_CNT_W     = 5;

	// ****************************************************************
	// Word receiver states
	// ****************************************************************
	typedef enum logic [1:0] {
		RX_IDLE  = 2'b00,
		RX_SHIFT = 2'b01,
		RX_FULL  = 2'b10
	} odcpc_rx_state_t;

endpackage : odcpc_pkg

//--- rtl/odcpc_wake_timer.sv
`timescale 1ns/1ps

module odcpc_wake_timer #(
	parameter int WAKE = odcpc_pkg::WAKE_CYCLES
) (
	// Clock and reset
	input  wire logic ref_clk,
	input  wire logic rst,
	// Channel state
	input  wire logic poweredUp,
	output logic      ready
);

	logic [odcpc_pkg::WAKE_CNT_W-1:0] cnt_q;
	logic                             ready_q;

	assign ready = ready_q;

	// Ready drops while down and stays low for the full settle time after power-up
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			cnt_q   <= '0;
			ready_q <= 1'b1;
		end else if (!poweredUp) begin
			cnt_q   <= odcpc_pkg::WAKE_CNT_W'(WAKE);
			ready_q <= 1'b0;
		end else if (cnt_q != '0) begin
			cnt_q   <= cnt_q - 1'b1;
			ready_q <= (cnt_q == odcpc_pkg::WAKE_CNT_W'(1));
		end
	end

endmodule : odcpc_wake_timer

//--- rtl/odcpc_core.sv
`timescale 1ns/1ps

module odcpc_core #(
	parameter int DATA_W      = 16,
	parameter bit MID_DEFAULT = 1'b0,
	parameter int POR_CYCLES  = odcpc_pkg::POR_CYCLES,
	parameter int WAKE        = odcpc_pkg::WAKE_CYCLES
) (
	// Clock and reset
	input  wire logic                                   ref_clk,
	input  wire logic                                   rst,
	// Command word from the serial front end
	input  wire logic                                   frameStart,
	input  wire logic                                   bitStrobe,
	input  wire logic                                   bitData,
	input  wire logic                                   frameStop,
	// Pins
	input  wire logic                                   load_strobe_n,
	input  wire logic                                   async_clear_n,
	// Channel outputs
	output logic [odcpc_pkg::NUM_CH*DATA_W-1:0]         dacCode,
	output logic [odcpc_pkg::NUM_CH*2-1:0]              pdModes,
	output logic [odcpc_pkg::NUM_CH-1:0]                chanReady,
	// Status
	output logic                                        refOn,
	output logic                                        clearModeActive,
	output logic                                        porBusy,
	output logic                                        wordAccepted
);

	localparam int                NCH      = odcpc_pkg::NUM_CH;
	localparam logic [DATA_W-1:0] POR_CODE = MID_DEFAULT ?
		odcpc_pkg::CODE_MID[15 -: DATA_W] : odcpc_pkg::CODE_ZERO[15 -: DATA_W];

	// ****************************************************************
	// Pin synchronisers
	// ****************************************************************
	// Three stages; a new level is accepted only when stages two and three agree
	logic [2:0] ldacSync_q;
	logic [2:0] clrSync_q;
	logic       ldacLevel_q;
	logic       clrLevel_q;
	logic       clrPrev_q;

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			ldacSync_q <= 3'h7;
			clrSync_q  <= 3'h7;
		end else begin
			ldacSync_q <= {ldacSync_q[1:0], load_strobe_n};
			clrSync_q  <= {clrSync_q[1:0], async_clear_n};
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			ldacLevel_q <= 1'b1;
			clrLevel_q  <= 1'b1;
			clrPrev_q   <= 1'b1;
		end else begin
			if (ldacSync_q[1] == ldacSync_q[2])
				ldacLevel_q <= ldacSync_q[2];
			if (clrSync_q[1] == clrSync_q[2])
				clrLevel_q <= clrSync_q[2];
			clrPrev_q <= clrLevel_q;
		end
	end

	// ****************************************************************
	// Power-on reset window
	// ****************************************************************
	logic                             swReset;
	logic                             rstAll;
	logic [odcpc_pkg::POR_CNT_W-1:0]  porCnt_q;
	logic                             porBusy_q;
	wire  logic                       clearEvent;
	wire  logic                       ldacActive;

	assign rstAll     = rst | swReset;
	assign porBusy    = porBusy_q;
	assign clearEvent = clrPrev_q & ~clrLevel_q & ~porBusy_q;
	assign ldacActive = ~ldacLevel_q & ~porBusy_q;

	always_ff @(posedge ref_clk) begin
		if (rstAll) begin
			porCnt_q  <= odcpc_pkg::POR_CNT_W'(POR_CYCLES);
			porBusy_q <= 1'b1;
		end else if (porCnt_q != '0) begin
			porCnt_q  <= porCnt_q - 1'b1;
			porBusy_q <= (porCnt_q != odcpc_pkg::POR_CNT_W'(1));
		end
	end

	// ****************************************************************
	// Command word receiver
	// ****************************************************************
	odcpc_pkg::odcpc_rx_state_t       rxState_q;
	odcpc_pkg::odcpc_rx_state_t       rxState_d;
	logic [odcpc_pkg::WORD_W-1:0]     word_q;
	logic [odcpc_pkg::BIT_CNT_W-1:0]  bitCnt_q;
	logic                             cmdDone;

	assign cmdDone = (rxState_q == odcpc_pkg::RX_FULL) & frameStop & ~clearEvent;

	always_comb begin
		rxState_d = rxState_q;
		unique case (rxState_q)
			odcpc_pkg::RX_IDLE: begin
				if (frameStart)
					rxState_d = odcpc_pkg::RX_SHIFT;
			end
			odcpc_pkg::RX_SHIFT: begin
				if (frameStop)
					rxState_d = odcpc_pkg::RX_IDLE;
				else if (bitStrobe && bitCnt_q == odcpc_pkg::LAST_BIT)
					rxState_d = odcpc_pkg::RX_FULL;
			end
			odcpc_pkg::RX_FULL: begin
				if (frameStop)
					rxState_d = odcpc_pkg::RX_IDLE;
			end
			default: rxState_d = odcpc_pkg::RX_IDLE;
		endcase
		if (clearEvent)
			rxState_d = odcpc_pkg::RX_IDLE;
		else if (frameStart)
			rxState_d = odcpc_pkg::RX_SHIFT;
	end

	always_ff @(posedge ref_clk) begin
		if (rstAll) begin
			rxState_q <= odcpc_pkg::RX_IDLE;
			bitCnt_q  <= '0;
			word_q    <= '0;
		end else begin
			rxState_q <= rxState_d;
			if (frameStart || clearEvent)
				bitCnt_q <= '0;
			else if (rxState_q == odcpc_pkg::RX_SHIFT && bitStrobe) begin
				bitCnt_q <= bitCnt_q + 1'b1;
				word_q   <= {word_q[odcpc_pkg::WORD_W-2:0], bitData};
			end
		end
	end

	// ****************************************************************
	// Word fields and command decode
	// ****************************************************************
	wire logic [3:0]        cmd;
	wire logic [3:0]        addr;
	wire logic [DATA_W-1:0] data;
	wire logic [1:0]        pdField;
	wire logic [1:0]        clrField;
	wire logic              isWrite;
	wire logic              isUpdN;
	wire logic              isUpdAll;
	wire logic              isPower;
	wire logic              isClrLoad;
	wire logic              isRef;

	assign cmd       = word_q[odcpc_pkg::CMD_MSB:odcpc_pkg::CMD_LSB];
	assign addr      = word_q[odcpc_pkg::ADDR_MSB:odcpc_pkg::ADDR_LSB];
	assign data      = word_q[odcpc_pkg::DATA_MSB -: DATA_W];
	assign pdField   = word_q[odcpc_pkg::PD_HI_BIT:odcpc_pkg::PD_LO_BIT];
	assign clrField  = word_q[odcpc_pkg::CLR_SEL_HI:odcpc_pkg::CLR_SEL_LO];
	assign isWrite   = cmdDone & (cmd == odcpc_pkg::CMD_WR_INPUT
		| cmd == odcpc_pkg::CMD_WR_UPD_ALL | cmd == odcpc_pkg::CMD_WR_UPD_N);
	assign isUpdN    = cmdDone & (cmd == odcpc_pkg::CMD_UPD_DAC | cmd == odcpc_pkg::CMD_WR_UPD_N);
	assign isUpdAll  = cmdDone & (cmd == odcpc_pkg::CMD_WR_UPD_ALL);
	assign isPower   = cmdDone & (cmd == odcpc_pkg::CMD_POWER);
	assign isClrLoad = cmdDone & (cmd == odcpc_pkg::CMD_CLR_CODE);
	assign isRef     = cmdDone & (cmd == odcpc_pkg::CMD_REF);
	assign swReset   = cmdDone & (cmd == odcpc_pkg::CMD_SW_RESET);

	// ****************************************************************
	// Clear code, clear mode and reference
	// ****************************************************************
	logic [1:0]             clrSel_q;
	logic                   clearMode_q;
	logic                   refEn_q;
	logic                   refOn_q;
	logic                   wordAcc_q;
	logic [DATA_W-1:0]      clearCode;
	wire  logic             allDown;

	// Select 11 never reaches the register, so the code map needs no entry for it
	always_comb begin
		unique case (clrSel_q)
			odcpc_pkg::CLR_SEL_MID:  clearCode = odcpc_pkg::CODE_MID[15 -: DATA_W];
			odcpc_pkg::CLR_SEL_FULL: clearCode = odcpc_pkg::CODE_FULL[15 -: DATA_W];
			default:                 clearCode = odcpc_pkg::CODE_ZERO[15 -: DATA_W];
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (rstAll) begin
			clrSel_q    <= odcpc_pkg::CLR_SEL_ZERO;
			clearMode_q <= 1'b0;
			refEn_q     <= odcpc_pkg::REF_RESET;
			refOn_q     <= odcpc_pkg::REF_RESET;
			wordAcc_q   <= 1'b0;
		end else begin
			if (isClrLoad && clrField != odcpc_pkg::CLR_SEL_NOP)
				clrSel_q <= clrField;
			if (clearEvent)
				clearMode_q <= 1'b1;
			else if (cmdDone)
				clearMode_q <= 1'b0;
			if (isRef)
				refEn_q <= word_q[odcpc_pkg::REF_EN_BIT];
			refOn_q   <= refEn_q & ~allDown;
			wordAcc_q <= cmdDone;
		end
	end

	assign clearModeActive = clearMode_q;
	assign refOn           = refOn_q;
	assign wordAccepted    = wordAcc_q;

	// ****************************************************************
	// Channels
	// ****************************************************************
	logic [NCH-1:0] downVec;

	assign allDown = &downVec;

	genvar ch;
	generate
		for (ch = 0; ch < NCH; ch++) begin : g_ch
			logic [DATA_W-1:0] inputReg_q;
			logic [DATA_W-1:0] dacReg_q;
			logic [1:0]        pd_q;
			wire  logic        sel;
			wire  logic        wrThis;
			wire  logic        updThis;
			wire  logic [DATA_W-1:0] srcIn;

			assign sel     = (addr == 4'(ch)) | (addr == odcpc_pkg::ADDR_ALL);
			assign wrThis  = isWrite & sel;
			// Strobe low copies continuously, so waking up shows the input value
			assign updThis = (isUpdN & sel) | isUpdAll | ldacActive;
			assign srcIn   = wrThis ? data : inputReg_q;

			// Clear has priority over a write finishing in the same cycle
			always_ff @(posedge ref_clk) begin
				if (rstAll) begin
					inputReg_q <= POR_CODE;
					dacReg_q   <= POR_CODE;
				end else if (clearEvent) begin
					inputReg_q <= clearCode;
					dacReg_q   <= clearCode;
				end else begin
					inputReg_q <= srcIn;
					if (updThis)
						dacReg_q <= srcIn;
				end
			end

			// Mode changes touch only the mode bits, never the stored codes
			always_ff @(posedge ref_clk) begin
				if (rstAll)
					pd_q <= odcpc_pkg::PD_NORMAL;
				else if (isPower && word_q[ch])
					pd_q <= pdField;
			end

			assign downVec[ch]                      = (pd_q != odcpc_pkg::PD_NORMAL);
			assign dacCode[ch*DATA_W +: DATA_W]     = dacReg_q;
			assign pdModes[ch*2 +: 2]               = pd_q;

			odcpc_wake_timer #(
				.WAKE      (WAKE)
			) u_wake (
				.ref_clk   (ref_clk),
				.rst       (rstAll),
				.poweredUp (~downVec[ch]),
				.ready     (chanReady[ch])
			);
		end
	endgenerate

endmodule : odcpc_core

//--- testbench/odcpc_host_model.sv
`timescale 1ns/1ps

// ****************************************************************
// Command word source on the far side of the block
// ****************************************************************
module odcpc_host_model (
	// Clock
	input  wire logic ref_clk,
	// Word interface
	output logic      frameStart,
	output logic      bitStrobe,
	output logic      bitData,
	output logic      frameStop
);
	initial begin
		frameStart = 1'b0;
		bitStrobe  = 1'b0;
		bitData    = 1'b0;
		frameStop  = 1'b0;
	end

	// Sends nbits of w, MSB first; under 24 bits makes a word that must be refused
	task automatic send(input logic [23:0] w, input int nbits);
		@(negedge ref_clk) frameStart = 1'b1;
		@(negedge ref_clk) frameStart = 1'b0;
		for (int i = 0; i < nbits; i++) begin
			bitStrobe = 1'b1;
			bitData   = w[23 - i];
			@(negedge ref_clk);
		end
		bitStrobe = 1'b0;
		// Line released: show the inverse so no stale bit can be mistaken for data
		bitData   = ~bitData;
		frameStop = 1'b1;
		@(negedge ref_clk) frameStop = 1'b0;
	endtask : send
endmodule : odcpc_host_model

//--- testbench/odcpc_core_properties.sv
`timescale 1ns/1ps

// ****************************************************************
// Port checker
// ****************************************************************
module odcpc_core_checker #(
	parameter int DATA_W      = 16,
	parameter bit MID_DEFAULT = 1'b0,
	parameter int POR_CYCLES  = 16,
	parameter int WAKE        = 200
) (
	input wire logic                           ref_clk,
	input wire logic                           rst,
	input wire logic                           frameStop,
	input wire logic [odcpc_pkg::NUM_CH*DATA_W-1:0] dacCode,
	input wire logic [odcpc_pkg::NUM_CH*2-1:0] pdModes,
	input wire logic [odcpc_pkg::NUM_CH-1:0]   chanReady,
	input wire logic                           refOn,
	input wire logic                           clearModeActive,
	input wire logic                           porBusy,
	input wire logic                           wordAccepted
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);

	logic [7:0] chDown;
	for (genvar i = 0; i < 8; i++) begin : g_down
		assign chDown[i] = |pdModes[2*i+:2];
	end

	property p_por_busy; $fell(rst) |-> porBusy && !refOn && pdModes == 16'h0000; endproperty
	a_por_busy: assert property (p_por_busy) else $error("reset state wrong");
	property p_busy_noclear; porBusy |-> !clearModeActive; endproperty
	a_busy_noclear: assert property (p_busy_noclear) else $error("clear acted in reset");
	property p_ref_off; (&chDown) |=> !refOn; endproperty
	a_ref_off: assert property (p_ref_off) else $error("reference on while all down");
	property p_ready_low; chDown[0] |=> !chanReady[0]; endproperty
	a_ready_low: assert property (p_ready_low) else $error("ready while down");
	property p_wake_time;
		$fell(chDown[0]) && !porBusy |-> !chanReady[0] ##WAKE $rose(chanReady[0]);
	endproperty
	a_wake_time: assert property (p_wake_time) else $error("wake timing wrong");
	property p_pd_keeps; $changed(pdModes) && !porBusy |-> $stable(dacCode); endproperty
	a_pd_keeps: assert property (p_pd_keeps) else $error("codes moved on mode change");
	property p_clear_all;
		$rose(clearModeActive) |-> dacCode == {odcpc_pkg::NUM_CH{dacCode[DATA_W-1:0]}};
	endproperty
	a_clear_all: assert property (p_clear_all) else $error("clear not on all");
	property p_clear_exit; $fell(clearModeActive) && !porBusy |-> wordAccepted; endproperty
	a_clear_exit: assert property (p_clear_exit) else $error("clear left early");
	property p_accept;
		wordAccepted |-> ($past(frameStop) || $past(frameStop, 2)) ##1 !wordAccepted;
	endproperty
	a_accept: assert property (p_accept) else $error("accept pulse wrong");

	c_clear: cover property ($rose(clearModeActive));
	c_accept: cover property (wordAccepted);
	c_wake: cover property ($fell(chDown[0]));
endmodule : odcpc_core_checker

bind odcpc_core odcpc_core_checker #(
	.DATA_W(DATA_W), .MID_DEFAULT(MID_DEFAULT), .POR_CYCLES(POR_CYCLES), .WAKE(WAKE)
) chk (
	.ref_clk(ref_clk), .rst(rst), .frameStop(frameStop), .dacCode(dacCode),
	.pdModes(pdModes), .chanReady(chanReady), .refOn(refOn),
	.clearModeActive(clearModeActive), .porBusy(porBusy), .wordAccepted(wordAccepted)
);

//--- testbench/tb_top.sv
`timescale 1ns/1ps

// ****************************************************************
// Testbench
// ****************************************************************
module tb_top;
	logic         ref_clk = 1'b0;
	logic         rst = 1'b1;
	logic         load_strobe_n = 1'b1;
	logic         async_clear_n = 1'b1;
	logic         frameStart, bitStrobe, bitData, frameStop;
	logic [127:0] dacCode;
	logic [15:0]  pdModes, pdExp;
	logic [7:0]   chanReady;
	logic         refOn, clearModeActive, porBusy, wordAccepted;
	logic [31:0]  seed = 32'ha04e;
	logic [15:0]  cur;
	int           err_count, cmp_count, accCnt, n;
	int           inReg[8], dacReg[8];

	always #10 ref_clk = ~ref_clk;
	always @(posedge ref_clk) if (wordAccepted === 1'b1) accCnt++;

	odcpc_host_model host (.ref_clk(ref_clk), .frameStart(frameStart), .bitStrobe(bitStrobe),
		.bitData(bitData), .frameStop(frameStop));
	// Small wake count keeps the run short; expectations use the same value
	odcpc_core #(.DATA_W(16), .MID_DEFAULT(1'b0), .POR_CYCLES(16), .WAKE(8)) uut (
		.ref_clk(ref_clk), .rst(rst), .frameStart(frameStart), .bitStrobe(bitStrobe),
		.bitData(bitData), .frameStop(frameStop), .load_strobe_n(load_strobe_n),
		.async_clear_n(async_clear_n), .dacCode(dacCode), .pdModes(pdModes),
		.chanReady(chanReady), .refOn(refOn), .clearModeActive(clearModeActive),
		.porBusy(porBusy), .wordAccepted(wordAccepted));

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	task automatic chk_dac();
		for (int c = 0; c < 8; c++) chk("dacCode", dacReg[c], {16'h0, dacCode[c*16+:16]});
	endtask : chk_dac

	task automatic wr(input logic [3:0] c, input logic [3:0] a, input logic [15:0] d);
		int k;
		k = accCnt;
		host.send({c, a, d}, 24);
		repeat (3) @(negedge ref_clk);
		// Software reset clears the accept flag along with everything but the pin synchronisers
		chk("wordAccepted", (c == 4'h7) ? k : k + 1, accCnt);
		for (int i = 0; i < 8; i++) begin
			if ((c == 4'h0 || c == 4'h2 || c == 4'h3) && (a == i || a == 4'hf))
				inReg[i] = d;
			if (((c == 4'h1 || c == 4'h3) && (a == i || a == 4'hf)) || c == 4'h2)
				dacReg[i] = inReg[i];
			if (c == 4'h7) begin
				inReg[i]  = 0;
				dacReg[i] = 0;
			end
		end
	endtask : wr

	// Clear pin held low long enough to pass the pin filter
	task automatic clr_pulse();
		@(negedge ref_clk) async_clear_n = 1'b0;
		repeat (8) @(negedge ref_clk);
		async_clear_n = 1'b1;
		repeat (6) @(negedge ref_clk);
	endtask : clr_pulse

	task automatic wrap_up();
		$display("Comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : wrap_up

	initial begin
		#1ms;
		err_count++;
		wrap_up();
	end

	initial begin
		repeat (5) @(negedge ref_clk);
		rst = 1'b0;
		clr_pulse();
		repeat (10) @(negedge ref_clk);
		chk("clearModeActive", 0, clearModeActive);
		chk_dac();
		chk("refOn", 0, refOn);
		for (int c = 0; c < 8; c++) begin
			seed = lfsr(seed);
			wr(4'h3, c[3:0], seed[15:0]);
		end
		wr(4'h0, 4'h2, 16'h1234);
		chk_dac();
		@(negedge ref_clk) load_strobe_n = 1'b0;
		repeat (8) @(negedge ref_clk);
		load_strobe_n = 1'b1;
		dacReg[2] = inReg[2];
		chk_dac();
		seed = lfsr(seed);
		wr(4'h0, 4'h5, seed[15:0]);
		chk_dac();
		wr(4'h1, 4'h5, 16'h0000);
		chk_dac();
		wr(4'h0, 4'h4, seed[31:16]);
		seed = lfsr(seed);
		wr(4'h2, 4'h6, seed[15:0]);
		chk_dac();
		$display("Test writes done");
		wr(4'h8, 4'h0, 16'h0001);
		chk("refOn", 1, refOn);
		pdExp = 16'h0000;
		for (int m = 1; m < 4; m++) begin
			seed = lfsr(seed);
			wr(4'h4, 4'h0, {6'h0, m[1:0], seed[7:0] & 8'h7f});
			for (int c = 0; c < 7; c++) if (seed[c]) pdExp[2*c+:2] = m[1:0];
			chk("pdModes", pdExp, pdModes);
			chk("refOn", 1, refOn);
			chk_dac();
		end
		wr(4'h4, 4'h0, 16'h03ff);
		chk("refOn", 0, refOn);
		wr(4'h4, 4'h0, 16'h00ff);
		chk("pdModes", 0, pdModes);
		chk("chanReady", 0, chanReady);
		repeat (12) @(negedge ref_clk);
		chk("chanReady", 8'hff, chanReady);
		chk("refOn", 1, refOn);
		chk_dac();
		wr(4'h4, 4'h0, 16'h0108);
		chk("pdModes", 16'h0040, pdModes);
		seed = lfsr(seed);
		wr(4'h0, 4'h3, seed[15:0]);
		chk_dac();
		@(negedge ref_clk) load_strobe_n = 1'b0;
		wr(4'h4, 4'h0, 16'h0008);
		load_strobe_n = 1'b1;
		dacReg[3] = inReg[3];
		chk_dac();
		chk("pdModes", 0, pdModes);
		$display("Test power done");
		cur = 16'h0000;
		for (int s = 0; s < 4; s++) begin
			seed = lfsr(seed);
			wr(4'h5, seed[3:0], {14'h0, s[1:0]});
			if (s == 1) cur = 16'h8000;
			if (s == 2) cur = 16'hffff;
			for (int c = 0; c < 8; c++) begin
				dacReg[c] = cur;
				inReg[c]  = cur;
			end
			clr_pulse();
			chk_dac();
			chk("clearModeActive", 1, clearModeActive);
		end
		n = accCnt;
		fork
			host.send(24'h301234, 24);
			clr_pulse();
		join
		host.send(24'h305678, 20);
		repeat (4) @(negedge ref_clk);
		chk("wordAccepted", n, accCnt);
		chk_dac();
		chk("clearModeActive", 1, clearModeActive);
		wr(4'h3, 4'h1, 16'h0f0f);
		chk("clearModeActive", 0, clearModeActive);
		$display("Test clear done");
		wr(4'h7, 4'h0, 16'h0000);
		chk("porBusy", 1, porBusy);
		for (int c = 0; c < 8; c++) dacReg[c] = 0;
		chk_dac();
		chk("refOn", 0, refOn);
		repeat (20) @(negedge ref_clk);
		wr(4'h3, 4'hf, 16'h5a5a);
		for (int c = 0; c < 8; c++) begin
			dacReg[c] = 0;
			inReg[c]  = 0;
		end
		clr_pulse();
		chk_dac();
		$display("Test reset done");
		wrap_up();
	end
endmodule : tb_top
